// ===== twcl_loader.sv
`default_nettype none
`include "twcl_map.svh"

// Functional notes
// R1 - Serial data shifts into the shift register, one bit per shift clock.
// R2 - Host sends 160 bits, most significant bit first.
// R3 - Strobe high copies shift register to latch; outputs settle in 10 ms.
// R4 - Shift clocks with strobe high pass data straight into the latch.
// R5 - Host should keep strobe low while shifting bits.
// R6 - Power-down low tri-states all outputs; pull-up makes it default high.
// R7 - Until first load, all nine outputs carry the reference clock.
// R8 - Programmed outputs appear after the settle following a load, and again after power-down rises following a load.
// R9 - Serial data is sampled on the shift clock rising edge.
// R10 - Latch holds while strobe is low; changes only on load or strobe high.
module twcl_loader #(
  parameter int CFG_BITS = `TWCL_CFG_BITS,
  parameter int NUM_OUTS = `TWCL_NUM_OUTS,
  parameter int SETTLE_CYC = `TWCL_SETTLE_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Three-wire programming pins
  input wire logic serial_data,
  input wire logic shift_clk,
  input wire logic strobe,
  // Power-down pin, low powers down
  input wire logic power_down_tristate_n,
  // Reference and synthesised clocks, sampled levels
  input wire logic reference_input,
  input wire logic [NUM_OUTS-1:0] synth_clk,
  // Clock outputs with enables
  output logic [NUM_OUTS-1:0] clk_out,
  output logic [NUM_OUTS-1:0] clk_out_oe,
  // Configuration and status
  output logic [CFG_BITS-1:0] cfg_latch,
  output logic cfg_valid,
  output logic settling,
  output twcl_pkg::twcl_state_t out_state
);
  import twcl_pkg::*;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic data_s, sclk_s, stb_s, pd_n_s, ref_s;
  logic [NUM_OUTS-1:0] synth_s;

  // Power-down bit resets to its pull-up level, so no false edge
  twcl_sync #(.WIDTH(5), .RST_VAL(5'h02)) u_pins (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in({serial_data, shift_clk, strobe, power_down_tristate_n,
               reference_input}),
    .sync_out({data_s, sclk_s, stb_s, pd_n_s, ref_s})
  );

  twcl_sync #(.WIDTH(NUM_OUTS)) u_synth (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(synth_clk),
    .sync_out(synth_s)
  );

  // ****************************************
  // Shift register and latch
  // ****************************************
  logic sclk_d_ff, stb_d_ff, pd_d_ff;
  logic [CFG_BITS-1:0] shift_ff, nxt_shift;
  logic [CFG_BITS-1:0] nxt_latch;
  logic sclk_rise, stb_rise, pd_rise, load_now;

  // Edge detection on synchronised pins
  // R9 - rising edge sample
  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign stb_rise = stb_s & ~stb_d_ff;
  assign pd_rise = pd_n_s & ~pd_d_ff;
  // R1 - one bit per edge, MSB first
  assign nxt_shift = sclk_rise ? {shift_ff[CFG_BITS-2:0], data_s} : shift_ff;
  // R4 - pass-through while strobe high
  // R10 - hold when strobe low
  assign load_now = stb_rise | (stb_s & sclk_rise);
  // R3 - copy on strobe
  assign nxt_latch = load_now ? nxt_shift : cfg_latch;

  // Edge history and shifting
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_ff <= 1'b0;
      stb_d_ff <= 1'b0;
      pd_d_ff <= 1'b1;
      shift_ff <= '0;
      cfg_latch <= '0;
    end else begin
      sclk_d_ff <= sclk_s;
      stb_d_ff <= stb_s;
      pd_d_ff <= pd_n_s;
      shift_ff <= nxt_shift;
      cfg_latch <= nxt_latch;
    end
  end

  // ****************************************
  // Output state and settle timer
  // ****************************************
  twcl_state_t state_ff, nxt_state;
  logic [31:0] settle_ff, nxt_settle;
  logic valid_ff, nxt_valid;

  // State sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_settle = settle_ff;
    nxt_valid = valid_ff | load_now;
    case (state_ff)
      TWCL_ST_OFF: begin
        if (pd_n_s) begin
          // R8 - programmed after power-up
          nxt_state = nxt_valid ? TWCL_ST_SETTLE : TWCL_ST_REF;
          nxt_settle = 32'(SETTLE_CYC);
        end
      end
      TWCL_ST_REF, TWCL_ST_SETTLE, TWCL_ST_PROG: begin
        if (load_now) begin
          nxt_state = TWCL_ST_SETTLE;
          nxt_settle = 32'(SETTLE_CYC);
        end else if (state_ff == TWCL_ST_SETTLE) begin
          // R3 - settle within 10 ms
          if (settle_ff <= 32'd1) nxt_state = TWCL_ST_PROG;
          nxt_settle = settle_ff - 32'd1;
        end
      end
      default: nxt_state = TWCL_ST_OFF;
    endcase
    // R6 - power down wins
    if (!pd_n_s) nxt_state = TWCL_ST_OFF;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= TWCL_ST_REF;
      settle_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      settle_ff <= nxt_settle;
      valid_ff <= nxt_valid;
    end
  end

  // ****************************************
  // Clock output drive
  // ****************************************
  logic [NUM_OUTS-1:0] nxt_clk, nxt_oe;

  // Per-output source selection
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUTS; gi++) begin : g_out
      // R7 - reference until programmed
      assign nxt_clk[gi] = (nxt_state == TWCL_ST_PROG) ? synth_s[gi] : ref_s;
      // R6 - tri-state when powered down
      assign nxt_oe[gi] = (nxt_state != TWCL_ST_OFF);
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      clk_out <= '0;
      clk_out_oe <= '0;
      cfg_valid <= 1'b0;
      settling <= 1'b0;
      out_state <= TWCL_ST_REF;
    end else begin
      clk_out <= nxt_clk & nxt_oe;
      clk_out_oe <= nxt_oe;
      cfg_valid <= nxt_valid;
      settling <= (nxt_state == TWCL_ST_SETTLE);
      out_state <= nxt_state;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_pd_tristate: assert property ( // R6
    @(posedge sys_clk) disable iff (!nrst)
    !pd_n_s |=> (clk_out_oe == '0))
    else $error("outputs enabled while powered down");

  a_shift_msb: assert property ( // R1
    @(posedge sys_clk) disable iff (!nrst)
    sclk_rise |=> shift_ff[0] == $past(data_s))
    else $error("shift did not take data");

  a_latch_hold: assert property ( // R10
    @(posedge sys_clk) disable iff (!nrst)
    !stb_s && !stb_d_ff |=> $stable(cfg_latch))
    else $error("latch changed with strobe low");

  a_strobe_load: assert property ( // R3
    @(posedge sys_clk) disable iff (!nrst)
    stb_rise |=> cfg_latch == $past(nxt_shift) && cfg_valid)
    else $error("strobe did not load latch");

  a_ref_default: assert property ( // R7
    @(posedge sys_clk) disable iff (!nrst)
    !valid_ff && pd_d_ff && pd_n_s |=> clk_out == {NUM_OUTS{$past(ref_s)}})
    else $error("default output not reference");

  a_pass_through: assert property ( // R4
    @(posedge sys_clk) disable iff (!nrst)
    stb_s && stb_d_ff && sclk_rise |=> cfg_latch == shift_ff)
    else $error("strobe high did not pass data");

  a_rise_edge: assert property ( // R9
    @(posedge sys_clk) disable iff (!nrst)
    !sclk_rise |=> $stable(shift_ff))
    else $error("shift without rising edge");

  a_pd_settle: assert property ( // R8
    @(posedge sys_clk) disable iff (!nrst)
    pd_rise && valid_ff |=> out_state == TWCL_ST_SETTLE)
    else $error("no settle after power-up");

  // Load while powered up starts the settle timer
  sequence s_load_up;
    load_now && pd_n_s;
  endsequence

  // Last settle count with nothing to restart it
  sequence s_settle_last;
    state_ff == TWCL_ST_SETTLE && settle_ff <= 32'd1 && !load_now && pd_n_s;
  endsequence

  a_settle_start: assert property ( // R3
    @(posedge sys_clk) disable iff (!nrst)
    s_load_up |=> settling && out_state == TWCL_ST_SETTLE)
    else $error("load did not start settle");

  a_settle_end: assert property ( // R3
    @(posedge sys_clk) disable iff (!nrst)
    s_settle_last |=> out_state == TWCL_ST_PROG && !settling)
    else $error("settle did not end");
endmodule : twcl_loader
`default_nettype wire

// ===== twcl_map.svh
`ifndef TWCL_MAP_SVH
`define TWCL_MAP_SVH
// Configuration word length in bits
`define TWCL_CFG_BITS 160
// Number of clock outputs
`define TWCL_NUM_OUTS 9
// Settle time after a load, in ms
`define TWCL_SETTLE_MS 10
// System clock rate in kHz
`define TWCL_SYS_KHZ 100000
// Settle time in system clock cycles
`define TWCL_SETTLE_CYC (`TWCL_SETTLE_MS * `TWCL_SYS_KHZ)
`endif

// ===== twcl_pkg.sv
`default_nettype none
package twcl_pkg;
  // Output state of the clock bank
  typedef enum logic [1:0] {
    TWCL_ST_OFF,
    TWCL_ST_REF,
    TWCL_ST_SETTLE,
    TWCL_ST_PROG
  } twcl_state_t;
endpackage : twcl_pkg
`default_nettype wire

// ===== twcl_sync.sv
`default_nettype none
// Two flip-flop level synchroniser, one per bit
module twcl_sync #(
  parameter int WIDTH = 1,
  // Per-bit reset level, set to the idle level of each pin
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;

  // First stage only feeds the second
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : twcl_sync
`default_nettype wire

// ===== twcl_host_model.sv
`default_nettype none
// ************************************************
// Host driving the three-wire programming port
// ************************************************
module twcl_host_model (
  // Clock
  input wire logic sys_clk,
  // Programming pins
  output logic serial_data,
  output logic shift_clk,
  output logic strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle pins at time zero
  initial begin
    serial_data = 1'b0;
    shift_clk = 1'b0;
    strobe = 1'b0;
  end

  // Wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One shift pulse, four cycles low, four high, then two low
  task automatic pulse(input logic b);
    serial_data = b;
    tick(4);
    shift_clk = 1'b1;
    tick(4);
    shift_clk = 1'b0;
    tick(1);
    serial_data = ~b; // Hold over, line no longer valid
    tick(1);
  endtask

  task automatic send(input logic [159:0] w);
    strobe = 1'b0;
    for (int i = 159; i >= 0; i--) begin
      pulse(w[i]);
    end
  endtask

  task automatic set_strobe(input logic v);
    strobe = v;
    tick(4);
  endtask
endmodule // twcl_host_model
`default_nettype wire

// ===== testbench.sv
`default_nettype none
// ************************************************
// Self-checking bench for the loader
// ************************************************
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import twcl_pkg::*;
  localparam int SETTLE = 20;
  localparam logic [159:0] W1 = {5{32'hc3a5_0f1e}};
  localparam logic [159:0] W2 = {5{32'h5a69_e187}};
  logic sys_clk, nrst, serial_data, shift_clk, strobe, pd_n, ref_in;
  logic valid, settling;
  logic [8:0] synth, clk_out, oe;
  logic [159:0] cfg;
  twcl_state_t st;
  int n_fail, tests_run;

  // Host model and design
  twcl_host_model host (.sys_clk(sys_clk), .serial_data(serial_data),
    .shift_clk(shift_clk), .strobe(strobe));
  twcl_loader #(.SETTLE_CYC(SETTLE)) DUT (.sys_clk(sys_clk), .nrst(nrst),
    .serial_data(serial_data), .shift_clk(shift_clk), .strobe(strobe),
    .power_down_tristate_n(pd_n), .reference_input(ref_in),
    .synth_clk(synth), .clk_out(clk_out), .clk_out_oe(oe),
    .cfg_latch(cfg), .cfg_valid(valid), .settling(settling),
    .out_state(st));

  // Clock generator
  always #5 sys_clk = ~sys_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check_word(input logic [159:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_state(input twcl_state_t got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_clk(input logic [8:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Bounded wait for an output state
  task automatic wait_state(input twcl_state_t s);
    for (int i = 0; i < 100 && st !== s; i++) tick(1);
    if (st !== s) begin
      check_state(st, s);
      print_verdict();
    end
  endtask

  // Unprogrammed outputs copy the reference
  task automatic scn_default;
    ref_in = 1'b1;
    tick(6);
    check_clk(clk_out, 9'h1ff);
    check_clk(oe, 9'h1ff);
    ref_in = 1'b0;
    tick(6);
    check_clk(clk_out, 9'h000);
    check_flag(valid, 1'b0);
    check_flag(settling, 1'b0);
    check_state(st, TWCL_ST_REF);
  endtask

  // Full load, settle, then synthesised clocks
  task automatic scn_load;
    host.send(W1);
    host.set_strobe(1'b1);
    check_word(cfg, W1);
    check_flag(valid, 1'b1);
    check_flag(settling, 1'b1);
    check_state(st, TWCL_ST_SETTLE);
    host.set_strobe(1'b0);
    wait_state(TWCL_ST_SETTLE);
    wait_state(TWCL_ST_PROG);
    check_flag(settling, 1'b0);
    synth = 9'h1a5;
    tick(6);
    check_clk(clk_out, 9'h1a5);
  endtask

  // Latch holds, then strobe high passes shifts through
  task automatic scn_hold;
    host.send(W2);
    check_word(cfg, W1);
    host.set_strobe(1'b1);
    check_word(cfg, W2);
    host.pulse(1'b1);
    check_word(cfg, {W2[158:0], 1'b1});
    host.set_strobe(1'b0);
  endtask

  // Power-down tri-states, rise restores programming
  task automatic scn_power;
    pd_n = 1'b0;
    tick(6);
    check_clk(oe, 9'h000);
    check_clk(clk_out, 9'h000);
    check_state(st, TWCL_ST_OFF);
    host.set_strobe(1'b1);
    host.set_strobe(1'b0);
    check_state(st, TWCL_ST_OFF);
    check_clk(oe, 9'h000);
    pd_n = 1'b1;
    wait_state(TWCL_ST_SETTLE);
    check_clk(clk_out, 9'h000);
    check_flag(settling, 1'b1);
    wait_state(TWCL_ST_PROG);
    tick(6);
    check_clk(oe, 9'h1ff);
    check_clk(clk_out, 9'h1a5);
  endtask

  // Main sequence
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    pd_n = 1'b1;
    ref_in = 1'b0;
    synth = 9'h000;
    n_fail = 0;
    tests_run = 0;
    tick(12);
    nrst = 1'b1;
    tick(6);
    scn_default();
    scn_load();
    scn_hold();
    scn_power();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
